// ### design/udm_pkg.sv
// udm_pkg: constants and types shared by the uart pin logic and its host
package udm_pkg;
  localparam int ADDR_W = 3;
  localparam int FIFO_DEPTH = 16;
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] OVS_MID = 4'h7;
  // register indices on the device's three address pins
  localparam logic [2:0] REG_DATA = 3'h0;
  localparam logic [2:0] REG_IER = 3'h1;
  localparam logic [2:0] REG_FCR = 3'h2;
  localparam logic [2:0] REG_LCR = 3'h3;
  localparam logic [2:0] REG_MCR = 3'h4;
  localparam logic [2:0] REG_LSR = 3'h5;
  localparam logic [2:0] REG_MSR = 3'h6;
  localparam logic [2:0] REG_SCR = 3'h7;
  // field positions
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_OUT1 = 2;
  localparam int MCR_OUT2 = 3;
  localparam int MCR_LOOP = 4;
  localparam int MSR_RING_TRAILING_EDGE_FLAG = 2;
  localparam int MSR_RI = 6;
  localparam int FCR_EN = 0;
  localparam int FCR_RXCLR = 1;
  localparam int FCR_TXCLR = 2;
  localparam int FCR_DMA = 3;
  localparam int IER_RDA = 0;
  localparam int IER_THRE = 1;
  localparam int IER_MSI = 3;
  localparam int LSR_DR = 0;
  localparam int LSR_THRE = 5;
  localparam int LSR_TEMT = 6;
  localparam logic [7:0] IIR_NONE = 8'h01;
  localparam logic [7:0] IIR_RDA = 8'h04;
  localparam logic [7:0] IIR_THRE = 8'h02;
  localparam logic [7:0] IIR_MSI = 8'h00;
  // receive trigger levels selected by the top two fifo control bits
  localparam logic [4:0] RX_TRIG_L0 = 5'h01;
  localparam logic [4:0] RX_TRIG_L1 = 5'h04;
  localparam logic [4:0] RX_TRIG_L2 = 5'h08;
  localparam logic [4:0] RX_TRIG_L3 = 5'h0e;
  // character timeout: four 10-bit characters of 16x ticks
  localparam int TIMEOUT_TICKS = 4 * 10 * OVERSAMPLE;
  // host timing at 100 MHz
  localparam int CLK_MHZ = 100;
  localparam int STROBE_NS = 20;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int REF_HALF_NS = 40;
  localparam int REF_HALF_CYC = (REF_HALF_NS * CLK_MHZ) / 1000;
  // host apb register offsets
  localparam logic [11:0] HOST_CMD_OFF = 12'h000;
  localparam logic [11:0] HOST_STAT_OFF = 12'h004;
  localparam logic [11:0] HOST_DMA_OFF = 12'h008;
  localparam logic [11:0] HOST_DSTAT_OFF = 12'h00c;
  localparam logic [11:0] HOST_MR_OFF = 12'h010;
  typedef enum logic [3:0] {
    SER_IDLE = 4'b0001,
    SER_START = 4'b0010,
    SER_DATA = 4'b0100,
    SER_STOP = 4'b1000
  } udm_ser_t;
  typedef enum logic [3:0] {
    HC_IDLE = 4'b0001,
    HC_SETUP = 4'b0010,
    HC_STROBE = 4'b0100,
    HC_RECOV = 4'b1000
  } udm_hc_t;
endpackage

// ### design/udm_if.sv
// udm_if: parallel bus, dma and clock pins between host and uart
`timescale 1ns/1ns
interface udm_if;
  import udm_pkg::*;
  logic chip_select_a;
  logic chip_select_b;
  logic chip_select_n;
  logic [ADDR_W-1:0] addr;
  logic rd_hi;
  logic rd_n;
  logic wr_hi;
  logic wr_n;
  logic [7:0] host_dout;
  logic host_oe;
  logic [7:0] dev_dout;
  logic dev_oe;
  logic [7:0] data_bus;
  logic rx_dma_request_n;
  logic tx_dma_request_n;
  logic intr;
  logic master_reset_pin;
  logic osc_input;
  logic rclk;
  // wire level of the shared data bus; pulled high when nobody drives
  assign data_bus = dev_oe ? dev_dout : (host_oe ? host_dout : 8'hff);
  modport dev (
    input chip_select_a, chip_select_b, chip_select_n, addr, rd_hi, rd_n, wr_hi, wr_n,
    input host_dout, master_reset_pin, osc_input, rclk,
    output dev_dout, dev_oe, rx_dma_request_n, tx_dma_request_n, intr
  );
  modport host (
    output chip_select_a, chip_select_b, chip_select_n, addr, rd_hi, rd_n, wr_hi, wr_n,
    output host_dout, host_oe, master_reset_pin, osc_input, rclk,
    input data_bus, rx_dma_request_n, tx_dma_request_n, intr
  );
endinterface

// ### design/udm_dev.sv
// udm_dev: uart register, fifo, dma request and modem pin logic
`timescale 1ns/1ns
// Operation
// - second user output low when control bit 3
// - master reset drives out2 and rts high
// - loopback holds modem outputs inactive
// - receiver timed from 16x receiver clock
// - read when selected and either strobe active
// - status bit 6 is inverted ring pin
// - status bit 2 latches ring rising edge
// - ring flag raises interrupt when enabled
// - rts low when control bit 1 set
// - master reset puts serial output at mark
// - dma mode bit only in fifo mode
// - rx mode 0 request while data present
// - rx mode 1 on trigger, until empty
// - tx mode 0 request while fifo empty
// - tx mode 1 from empty until full
// - dma controller bursts or single transfers
// - write when selected and either strobe active
// - host drives oscillator input externally
// - selected: both high selects, low select low
module udm_dev
  import udm_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH,
  parameter int TOUT_TICKS = TIMEOUT_TICKS
) (
  input wire logic pclk,
  input wire logic presetn,
  udm_if.dev bus,
  input wire logic serial_in,
  output logic serial_out,
  input wire logic ri_n,
  output logic out1_n,
  output logic out2_n,
  output logic rts_n,
  output logic dtr_n
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;
  localparam int TW = $clog2(TOUT_TICKS + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [TW-1:0] TOUT = TW'(TOUT_TICKS);

  typedef struct packed {
    logic [7:0] ier;
    logic [7:0] lcr;
    logic [7:0] modem_control_reg;
    logic [7:0] scr;
    logic fifo_en;
    logic dma_mode;
    logic [1:0] trig;
    logic ring_trailing_edge_flag;
    logic ri_q;
    logic rd_q;
    logic wr_q;
    logic [7:0] dout;
    logic osc_q;
    logic rclk_q;
    logic [DEPTH-1:0][7:0] rx_mem;
    logic [PW-1:0] rx_wp;
    logic [PW-1:0] rx_rp;
    logic [CW-1:0] rx_cnt;
    logic [DEPTH-1:0][7:0] tx_mem;
    logic [PW-1:0] tx_wp;
    logic [PW-1:0] tx_rp;
    logic [CW-1:0] tx_cnt;
    udm_ser_t rx_st;
    logic [3:0] rx_sub;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic [TW-1:0] rx_tout;
    udm_ser_t tx_st;
    logic [3:0] tx_sub;
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;
    logic tx_line;
    logic rx_req;
    logic tx_req;
  } udm_dev_st_t;

  localparam udm_dev_st_t DEV_RST = '{rx_st: SER_IDLE, tx_st: SER_IDLE, tx_line: 1'b1,
                                      ri_q: 1'b1, default: '0};

  udm_dev_st_t q;
  udm_dev_st_t d;
  logic sel, rd_act, wr_act, rd_go, wr_go, loop, ri_lvl_n, ri_rise, msr_rd;
  logic rx_tick, tx_tick, rx_in, rx_push, rx_pop, tx_push, tx_pop, rx_clr, tx_clr;
  logic tout_hit, irq;
  logic [CW-1:0] cap;
  logic [CW-1:0] trig_lvl;
  logic [7:0] rd_val, msr_val, lsr_val, iir_val;

  // interrupt from live flags; ring flag feeds the modem status source
  assign irq = (q.ier[IER_RDA] & (q.rx_cnt != '0)) | (q.ier[IER_THRE] & (q.tx_cnt == '0)) |
               (q.ier[IER_MSI] & q.ring_trailing_edge_flag);

  // next-state logic for the whole device
  always_comb begin
    d = q;
    sel = bus.chip_select_a & bus.chip_select_b & ~bus.chip_select_n;
    rd_act = sel & (bus.rd_hi | ~bus.rd_n);
    wr_act = sel & (bus.wr_hi | ~bus.wr_n);
    // side effects once per strobe, so a long strobe pops only one byte
    rd_go = rd_act & ~q.rd_q;
    wr_go = wr_act & ~q.wr_q;
    d.rd_q = rd_act;
    d.wr_q = wr_act;
    loop = q.modem_control_reg[MCR_LOOP];
    // in loopback the ring input follows the first user bit internally
    ri_lvl_n = loop ? ~q.modem_control_reg[MCR_OUT1] : ri_n;
    ri_rise = ri_lvl_n & ~q.ri_q;
    d.ri_q = ri_lvl_n;
    rx_tick = bus.rclk & ~q.rclk_q;
    d.rclk_q = bus.rclk;
    tx_tick = bus.osc_input & ~q.osc_q;
    d.osc_q = bus.osc_input;
    rx_in = loop ? q.tx_line : serial_in;
    cap = q.fifo_en ? FULL : CW'(1);
    tout_hit = (q.rx_tout == TOUT);
    trig_lvl = CW'(RX_TRIG_L0);
    case (q.trig)
      2'b01: trig_lvl = CW'(RX_TRIG_L1);
      2'b10: trig_lvl = CW'(RX_TRIG_L2);
      2'b11: trig_lvl = CW'(RX_TRIG_L3);
      default: trig_lvl = CW'(RX_TRIG_L0);
    endcase
    msr_val = 8'h00;
    msr_val[MSR_RI] = ~ri_lvl_n;
    msr_val[MSR_RING_TRAILING_EDGE_FLAG] = q.ring_trailing_edge_flag;
    lsr_val = 8'h00;
    lsr_val[LSR_DR] = (q.rx_cnt != '0);
    lsr_val[LSR_THRE] = (q.tx_cnt == '0);
    lsr_val[LSR_TEMT] = (q.tx_cnt == '0) && (q.tx_st == SER_IDLE);
    if (irq && q.ier[IER_RDA] && q.rx_cnt != '0) begin
      iir_val = IIR_RDA;
    end else if (irq && q.ier[IER_THRE] && q.tx_cnt == '0) begin
      iir_val = IIR_THRE;
    end else if (irq) begin
      iir_val = IIR_MSI;
    end else begin
      iir_val = IIR_NONE;
    end
    iir_val[7:6] = {2{q.fifo_en}};
    // read decode
    if (bus.addr == REG_DATA) begin
      rd_val = q.rx_mem[q.rx_rp];
    end else if (bus.addr == REG_IER) begin
      rd_val = q.ier;
    end else if (bus.addr == REG_FCR) begin
      rd_val = iir_val;
    end else if (bus.addr == REG_LCR) begin
      rd_val = q.lcr;
    end else if (bus.addr == REG_MCR) begin
      rd_val = q.modem_control_reg;
    end else if (bus.addr == REG_LSR) begin
      rd_val = lsr_val;
    end else if (bus.addr == REG_MSR) begin
      rd_val = msr_val;
    end else begin
      rd_val = q.scr;
    end
    if (rd_go) begin
      d.dout = rd_val;
    end
    rx_pop = rd_go && bus.addr == REG_DATA && q.rx_cnt != '0;
    msr_rd = rd_go && bus.addr == REG_MSR;
    // a rising edge in the reading cycle survives the clear
    d.ring_trailing_edge_flag = (q.ring_trailing_edge_flag & ~msr_rd) | ri_rise;
    // write decode; a byte written to a full transmit fifo is lost
    tx_push = wr_go && bus.addr == REG_DATA && q.tx_cnt < cap;
    rx_clr = 1'b0;
    tx_clr = 1'b0;
    if (wr_go) begin
      if (bus.addr == REG_IER) begin
        d.ier = bus.host_dout;
      end else if (bus.addr == REG_FCR) begin
        d.fifo_en = bus.host_dout[FCR_EN];
        d.dma_mode = bus.host_dout[FCR_DMA];
        d.trig = bus.host_dout[7:6];
        rx_clr = bus.host_dout[FCR_RXCLR] | (bus.host_dout[FCR_EN] != q.fifo_en);
        tx_clr = bus.host_dout[FCR_TXCLR] | (bus.host_dout[FCR_EN] != q.fifo_en);
      end else if (bus.addr == REG_LCR) begin
        d.lcr = bus.host_dout;
      end else if (bus.addr == REG_MCR) begin
        d.modem_control_reg = {3'b000, bus.host_dout[4:0]};
      end else if (bus.addr == REG_SCR) begin
        d.scr = bus.host_dout;
      end
    end
    // receiver: 8 data bits, one stop, sampled mid-bit on 16x ticks
    rx_push = 1'b0;
    if (rx_tick) begin
      case (q.rx_st)
        SER_IDLE: begin
          if (!rx_in) begin
            d.rx_st = SER_START;
            d.rx_sub = '0;
          end
        end
        SER_START: begin
          d.rx_sub = q.rx_sub + 4'h1;
          if (q.rx_sub == OVS_MID) begin
            d.rx_sub = '0;
            d.rx_bit = '0;
            d.rx_st = rx_in ? SER_IDLE : SER_DATA;
          end
        end
        SER_DATA: begin
          d.rx_sub = q.rx_sub + 4'h1;
          if (q.rx_sub == OVS_LAST) begin
            d.rx_sh = {rx_in, q.rx_sh[7:1]};
            d.rx_bit = q.rx_bit + 3'h1;
            if (q.rx_bit == 3'h7) begin
              d.rx_st = SER_STOP;
            end
          end
        end
        SER_STOP: begin
          d.rx_sub = q.rx_sub + 4'h1;
          if (q.rx_sub == OVS_LAST) begin
            d.rx_st = SER_IDLE;
            rx_push = rx_in && q.rx_cnt < cap; // bad stop bit or overrun drops it
          end
        end
        default: d.rx_st = SER_IDLE;
      endcase
    end
    // transmitter on reference ticks; baud divisor is fixed at one
    tx_pop = 1'b0;
    if (tx_tick) begin
      case (q.tx_st)
        SER_IDLE: begin
          if (q.tx_cnt != '0) begin
            tx_pop = 1'b1;
            d.tx_sh = q.tx_mem[q.tx_rp];
            d.tx_line = 1'b0;
            d.tx_sub = '0;
            d.tx_st = SER_START;
          end
        end
        SER_START: begin
          d.tx_sub = q.tx_sub + 4'h1;
          if (q.tx_sub == OVS_LAST) begin
            d.tx_line = q.tx_sh[0];
            d.tx_bit = '0;
            d.tx_st = SER_DATA;
          end
        end
        SER_DATA: begin
          d.tx_sub = q.tx_sub + 4'h1;
          if (q.tx_sub == OVS_LAST) begin
            d.tx_sh = q.tx_sh >> 1;
            d.tx_line = (q.tx_bit == 3'h7) ? 1'b1 : q.tx_sh[1];
            d.tx_bit = q.tx_bit + 3'h1;
            d.tx_st = (q.tx_bit == 3'h7) ? SER_STOP : SER_DATA;
          end
        end
        SER_STOP: begin
          d.tx_sub = q.tx_sub + 4'h1;
          if (q.tx_sub == OVS_LAST) begin
            d.tx_st = SER_IDLE;
          end
        end
        default: d.tx_st = SER_IDLE;
      endcase
    end
    // fifo pointers; depth must be a power of two for the wrap
    if (rx_push) begin
      d.rx_mem[q.rx_wp] = q.rx_sh;
    end
    d.rx_wp = q.rx_wp + PW'(rx_push);
    d.rx_rp = q.rx_rp + PW'(rx_pop);
    d.rx_cnt = q.rx_cnt + CW'(rx_push) - CW'(rx_pop);
    if (tx_push) begin
      d.tx_mem[q.tx_wp] = bus.host_dout;
    end
    d.tx_wp = q.tx_wp + PW'(tx_push);
    d.tx_rp = q.tx_rp + PW'(tx_pop);
    d.tx_cnt = q.tx_cnt + CW'(tx_push) - CW'(tx_pop);
    if (rx_clr) begin
      d.rx_wp = '0;
      d.rx_rp = '0;
      d.rx_cnt = '0;
    end
    if (tx_clr) begin
      d.tx_wp = '0;
      d.tx_rp = '0;
      d.tx_cnt = '0;
    end
    // character timeout restarts on any receive fifo push or pop
    if (rx_push || rx_pop || d.rx_cnt == '0) begin
      d.rx_tout = '0;
    end else if (rx_tick && !tout_hit) begin
      d.rx_tout = q.rx_tout + TW'(1);
    end
    // dma requests; multi-transfer only exists with the fifos on
    if (!(d.fifo_en && d.dma_mode)) begin
      d.rx_req = (d.rx_cnt != '0);
      d.tx_req = (d.tx_cnt == '0);
    end else begin
      if (d.rx_cnt == '0) begin
        d.rx_req = 1'b0;
      end else if (d.rx_cnt >= trig_lvl || tout_hit) begin
        d.rx_req = 1'b1;
      end
      if (d.tx_cnt == '0) begin
        d.tx_req = 1'b1;
      end else if (d.tx_cnt == FULL) begin
        d.tx_req = 1'b0;
      end
    end
    if (bus.master_reset_pin) begin
      d = DEV_RST;
    end
  end

  // single state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= DEV_RST;
    end else begin
      q <= d;
    end
  end

  // pin drives; loopback parks every modem output at its idle level
  assign bus.dev_dout = q.dout;
  assign bus.dev_oe = q.rd_q;
  assign bus.rx_dma_request_n = ~q.rx_req;
  assign bus.tx_dma_request_n = ~q.tx_req;
  assign bus.intr = irq;
  assign serial_out = loop ? 1'b1 : q.tx_line;
  assign out1_n = ~(q.modem_control_reg[MCR_OUT1] & ~loop);
  assign out2_n = ~(q.modem_control_reg[MCR_OUT2] & ~loop);
  assign rts_n = ~(q.modem_control_reg[MCR_RTS] & ~loop);
  assign dtr_n = ~(q.modem_control_reg[MCR_DTR] & ~loop);
endmodule // udm_dev

// ### design/udm_host.sv
// udm_host: apb-driven cpu bus cycles and dma controller for the uart
`timescale 1ns/1ns
module udm_host
  import udm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  udm_if.host bus
);
  localparam logic [1:0] STB_LAST = 2'(STROBE_CYC - 1);
  localparam logic [3:0] REF_LAST = 4'(REF_HALF_CYC - 1);

  typedef struct packed {
    udm_hc_t st;
    logic [1:0] scnt;
    logic cpu_pend;
    logic [2:0] cpu_addr;
    logic cpu_wr;
    logic [7:0] cpu_wdata;
    logic [7:0] cpu_rdata;
    logic cyc_dma;
    logic cyc_wr;
    logic [2:0] cyc_addr;
    logic [7:0] cyc_wdata;
    logic last_dma;
    logic rx_en;
    logic tx_en;
    logic multi;
    logic [7:0] tx_byte;
    logic [7:0] rx_byte;
    logic [15:0] dma_cnt;
    logic mr;
    logic [3:0] ref_cnt;
    logic ref_lvl;
    logic [31:0] prdata;
  } udm_host_st_t;

  localparam udm_host_st_t HOST_RST = '{st: HC_IDLE, default: '0};

  udm_host_st_t q;
  udm_host_st_t d;
  logic apb_wr, apb_setup, rx_want, tx_want, take_dma, mapped;

  // apb answers with no wait states; read data is caught in the setup cycle
  assign mapped = paddr == HOST_CMD_OFF || paddr == HOST_STAT_OFF || paddr == HOST_DMA_OFF ||
                  paddr == HOST_DSTAT_OFF || paddr == HOST_MR_OFF;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = q.prdata;

  always_comb begin
    d = q;
    apb_setup = psel & ~penable;
    apb_wr = psel & penable & pwrite;
    if (apb_setup && !pwrite) begin
      if (paddr == HOST_STAT_OFF) begin
        d.prdata = {13'h0000, bus.intr, ~bus.tx_dma_request_n, ~bus.rx_dma_request_n,
                    q.cpu_rdata, 7'h00, q.cpu_pend};
      end else if (paddr == HOST_DMA_OFF) begin
        d.prdata = {16'h0000, q.tx_byte, 5'h00, q.multi, q.tx_en, q.rx_en};
      end else if (paddr == HOST_DSTAT_OFF) begin
        d.prdata = {8'h00, q.dma_cnt, q.rx_byte};
      end else if (paddr == HOST_MR_OFF) begin
        d.prdata = {31'h0000_0000, q.mr};
      end else begin
        d.prdata = 32'h0000_0000;
      end
    end
    // a command written while one is pending is ignored
    if (apb_wr && paddr == HOST_CMD_OFF && !q.cpu_pend) begin
      d.cpu_pend = 1'b1;
      d.cpu_addr = pwdata[2:0];
      d.cpu_wr = pwdata[3];
      d.cpu_wdata = pwdata[15:8];
    end else if (apb_wr && paddr == HOST_DMA_OFF) begin
      d.rx_en = pwdata[0];
      d.tx_en = pwdata[1];
      d.multi = pwdata[2];
      d.tx_byte = pwdata[15:8];
    end else if (apb_wr && paddr == HOST_MR_OFF) begin
      d.mr = pwdata[0];
    end
    // free-running reference clock, also looped to the receiver clock
    d.ref_cnt = q.ref_cnt + 4'h1;
    if (q.ref_cnt == REF_LAST) begin
      d.ref_cnt = '0;
      d.ref_lvl = ~q.ref_lvl;
    end
    // dma arbitration: bursts keep the bus, single mode yields to the cpu
    rx_want = q.rx_en & ~bus.rx_dma_request_n;
    tx_want = q.tx_en & ~bus.tx_dma_request_n;
    take_dma = (rx_want | tx_want) & (q.multi | ~q.last_dma | ~q.cpu_pend);
    case (q.st)
      HC_IDLE: begin
        if (take_dma) begin
          d.st = HC_SETUP;
          d.cyc_dma = 1'b1;
          d.cyc_wr = ~rx_want;
          d.cyc_addr = REG_DATA;
          d.cyc_wdata = q.tx_byte;
        end else if (q.cpu_pend) begin
          d.st = HC_SETUP;
          d.cyc_dma = 1'b0;
          d.cyc_wr = q.cpu_wr;
          d.cyc_addr = q.cpu_addr;
          d.cyc_wdata = q.cpu_wdata;
        end
      end
      HC_SETUP: begin
        d.st = HC_STROBE;
        d.scnt = '0;
      end
      HC_STROBE: begin
        d.scnt = q.scnt + 2'h1;
        if (q.scnt == STB_LAST) begin
          d.st = HC_RECOV;
          d.last_dma = q.cyc_dma;
          if (q.cyc_dma) begin
            d.dma_cnt = q.dma_cnt + 16'h0001;
            if (q.cyc_wr) begin
              d.tx_byte = q.tx_byte + 8'h01;
            end else begin
              d.rx_byte = bus.data_bus;
            end
          end else begin
            d.cpu_pend = 1'b0;
            if (!q.cyc_wr) begin
              d.cpu_rdata = bus.data_bus;
            end
          end
        end
      end
      HC_RECOV: d.st = HC_IDLE;
      default: d.st = HC_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= HOST_RST;
    end else begin
      q <= d;
    end
  end

  // bus pins; only the active-high strobes are used, the others tied off
  assign bus.chip_select_a = (q.st != HC_IDLE);
  assign bus.chip_select_b = (q.st != HC_IDLE);
  assign bus.chip_select_n = (q.st == HC_IDLE);
  assign bus.addr = q.cyc_addr;
  assign bus.rd_hi = (q.st == HC_STROBE) & ~q.cyc_wr;
  assign bus.rd_n = 1'b1;
  assign bus.wr_hi = (q.st == HC_STROBE) & q.cyc_wr;
  assign bus.wr_n = 1'b1;
  assign bus.host_dout = q.cyc_wdata;
  assign bus.host_oe = (q.st != HC_IDLE) & q.cyc_wr;
  assign bus.master_reset_pin = q.mr;
  assign bus.osc_input = q.ref_lvl;
  assign bus.rclk = q.ref_lvl;
endmodule // udm_host

// ### verif/udm_chk.sv
// udm_chk: concurrent checks on the host to uart pins
`timescale 1ns/1ns
module udm_chk
  import udm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic chip_select_a,
  input wire logic chip_select_b,
  input wire logic chip_select_n,
  input wire logic rd_hi,
  input wire logic rd_n,
  input wire logic wr_hi,
  input wire logic wr_n,
  input wire logic host_oe,
  input wire logic dev_oe,
  input wire logic master_reset_pin,
  input wire logic rx_dma_request_n,
  input wire logic tx_dma_request_n,
  input wire logic intr,
  input wire logic serial_out,
  input wire logic out2_n,
  input wire logic rts_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic sel;
  // decoded select, all three pins must agree
  assign sel = chip_select_a && chip_select_b && !chip_select_n;
  property p_strobe_sel; (rd_hi || wr_hi) |-> sel; endproperty
  a_strobe_sel: assert property (p_strobe_sel) else $error("strobe without select");
  property p_tied; rd_n && wr_n; endproperty
  a_tied: assert property (p_tied) else $error("unused strobe not idle");
  property p_read_oe; (rd_hi && sel) |=> dev_oe; endproperty
  a_read_oe: assert property (p_read_oe) else $error("read not answered");
  property p_oe_idle; !rd_hi |=> !dev_oe; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("drive without read");
  property p_strobe_len; $rose(wr_hi) |=> wr_hi ##1 !wr_hi; endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("write strobe length");
  property p_mr_out; master_reset_pin |=> out2_n && rts_n; endproperty
  a_mr_out: assert property (p_mr_out) else $error("modem out active in reset");
  property p_mr_serial_out; master_reset_pin |=> serial_out; endproperty
  a_mr_serial_out: assert property (p_mr_serial_out) else $error("serial out not mark");
  property p_mr_rx; master_reset_pin |=> rx_dma_request_n && !intr; endproperty
  a_mr_rx: assert property (p_mr_rx) else $error("rx request in reset");
  property p_mr_tx; master_reset_pin ##1 !master_reset_pin |=> !tx_dma_request_n; endproperty
  a_mr_tx: assert property (p_mr_tx) else $error("tx request missing");
  property p_no_fight; !(dev_oe && host_oe); endproperty
  a_no_fight: assert property (p_no_fight) else $error("bus contention");
endmodule // udm_chk

// ### verif/uart_dma_modem_pin_logic_tb.sv
// uart_dma_modem_pin_logic_tb: apb bench joining host and uart ends
`timescale 1ns/1ns
module uart_dma_modem_pin_logic_tb;
  import udm_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, chk = 0, pchk = 0, ri_n = 1;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [31:0] exp_q[$], msk_q[$], pin_q[$];
  logic pready, pslverr, serial_out, out1_n, out2_n, rts_n, dtr_n;
  logic [7:0] b;
  wire logic [3:0] pins = {out1_n, out2_n, rts_n, dtr_n};
  int failures = 0, num_checks = 0, cyc = 0;
  udm_if bus_if ();
  udm_host udm_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus(bus_if.host));
  // serial line looped back outside the chip
  udm_dev #(.TOUT_TICKS(32)) udm_dev_inst (.pclk(pclk), .presetn(presetn), .bus(bus_if.dev),
    .serial_in(serial_out), .serial_out(serial_out), .ri_n(ri_n), .out1_n(out1_n),
    .out2_n(out2_n), .rts_n(rts_n), .dtr_n(dtr_n));
  udm_chk udm_chk_inst (.pclk(pclk), .presetn(presetn), .chip_select_a(bus_if.chip_select_a),
    .chip_select_b(bus_if.chip_select_b), .chip_select_n(bus_if.chip_select_n),
    .rd_hi(bus_if.rd_hi), .rd_n(bus_if.rd_n), .wr_hi(bus_if.wr_hi), .wr_n(bus_if.wr_n),
    .host_oe(bus_if.host_oe), .dev_oe(bus_if.dev_oe), .intr(bus_if.intr),
    .master_reset_pin(bus_if.master_reset_pin), .rx_dma_request_n(bus_if.rx_dma_request_n),
    .tx_dma_request_n(bus_if.tx_dma_request_n), .serial_out(serial_out), .out2_n(out2_n),
    .rts_n(rts_n));
  initial begin
    forever #5 pclk = ~pclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  // poll until the cpu bus cycle has finished; bounded
  task automatic wait_done();
    repeat (50) begin
      apb(1'b0, HOST_STAT_OFF, 32'h0);
      if (rd[0] === 1'b0) break;
    end
    // a bus cycle that never finishes is a failure, not a silent skip
    if (rd[0] !== 1'b0) failures++;
  endtask
  // expected read: noted in the queue, judged by the monitor
  task automatic xr(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge pclk);
    exp_q.push_back(e);
    msk_q.push_back(m);
    chk <= 1;
    apb(1'b0, a, 32'h0);
    chk <= 0;
  endtask
  // expected pin levels: noted here, judged by the monitor at the next edge
  task automatic xp(input logic [31:0] e);
    pin_q.push_back(e);
    pchk <= 1;
    @(posedge pclk);
    pchk <= 0;
  endtask
  task automatic uw(input logic [2:0] i, input logic [7:0] d);
    apb(1'b1, HOST_CMD_OFF, {16'h0000, d, 4'h0, 1'b1, i});
    wait_done();
  endtask
  task automatic ur(input logic [2:0] i, input logic [7:0] m, input logic [7:0] e);
    apb(1'b1, HOST_CMD_OFF, {29'h0, i});
    wait_done();
    xr(HOST_STAT_OFF, {16'h0000, m, 8'h00}, {16'h0000, e, 8'h00});
  endtask
  // monitor: every checked read is matched against the oldest note
  always @(posedge pclk) begin
    if (chk && psel && penable && pready) begin
      check(prdata & msk_q.pop_front(), exp_q.pop_front());
    end
    // only offsets up to the reset register are mapped in this bench
    if (psel && penable && pready) check({31'h0, pslverr}, {31'h0, paddr > HOST_MR_OFF});
    // pin levels seen before this edge updates them
    if (pchk) check({27'h0, serial_out, pins}, pin_q.pop_front());
  end
  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    void'($urandom(12685));
    repeat (10) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    xp(32'h0000_001f);
    xr(HOST_STAT_OFF, 32'h0003_0000, 32'h0002_0000);
    for (int k = 0; k < 6; k++) begin
      b = 8'($urandom()) & 8'h0f;
      uw(REG_MCR, b);
      xp({27'h0, 1'b1, ~b[2], ~b[3], ~b[1], ~b[0]});
    end
    uw(REG_MCR, 8'h1f);
    xp(32'h0000_001f);
    uw(REG_MCR, 8'h0b);
    apb(1'b1, HOST_MR_OFF, 32'h1);
    apb(1'b1, HOST_MR_OFF, 32'h0);
    xp(32'h0000_001f);
    // ring: pin rises after a low spell, flag and interrupt follow
    uw(REG_IER, 8'h08);
    ri_n <= 0;
    ur(REG_MSR, 8'h40, 8'h40);
    ri_n <= 1;
    xr(HOST_STAT_OFF, 32'h0004_0000, 32'h0004_0000);
    ur(REG_MSR, 8'h44, 8'h04);
    ur(REG_MSR, 8'h04, 8'h00);
    xr(HOST_STAT_OFF, 32'h0004_0000, 32'h0000_0000);
    // multi mode, trigger 4: one byte waits for the timeout
    uw(REG_FCR, 8'h49);
    b = 8'($urandom());
    uw(REG_DATA, b);
    repeat (1330) @(posedge pclk);
    xr(HOST_STAT_OFF, 32'h0001_0000, 32'h0000_0000);
    repeat (800) @(posedge pclk);
    xr(HOST_STAT_OFF, 32'h0001_0000, 32'h0001_0000);
    ur(REG_DATA, 8'hff, b);
    xr(HOST_STAT_OFF, 32'h0001_0000, 32'h0000_0000);
    // single mode: one byte is enough, then the dma engine drains it
    uw(REG_FCR, 8'h41);
    b = 8'($urandom());
    uw(REG_DATA, b);
    repeat (1330) @(posedge pclk);
    xr(HOST_STAT_OFF, 32'h0001_0000, 32'h0001_0000);
    apb(1'b1, HOST_DMA_OFF, 32'h1);
    repeat (20) @(posedge pclk);
    xr(HOST_DSTAT_OFF, 32'h00ff_ffff, {8'h00, 16'h0001, b});
    xr(HOST_STAT_OFF, 32'h0001_0000, 32'h0000_0000);
    // master reset in mid-character must park the line at mark
    uw(REG_DATA, 8'h00);
    repeat (300) @(posedge pclk);
    xp(32'h0000_000f);
    apb(1'b1, HOST_MR_OFF, 32'h1);
    apb(1'b1, HOST_MR_OFF, 32'h0);
    xp(32'h0000_001f);
    // unmapped host offset: error answer, no effect
    apb(1'b1, 12'h020, 32'h1);
    final_report();
  end
endmodule // uart_dma_modem_pin_logic_tb
